/* seq_defines.vh */
/*
 * Shared constants for the buck voltage-select sequencer.
 * Assumes a 40 MHz core clock and includes by bare name.
 */
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH

`define NUM_OUT            4
`define CODE_W             10
`define SLOT_SEL_W         2
`define RAMP_W             3
`define DLY_W              6
`define CLK_MHZ            40
`define BOOT_TIME_US       1400
`define BOOT_CYCLES        (`BOOT_TIME_US * `CLK_MHZ)
`define MS_CYCLES          (1000 * `CLK_MHZ)
`define PIN_MODE_GLOBAL    3'h4
`define PIN_MODE_TWO_ONE   3'h6
`define PIN_MODE_SINGLE    3'h7
`define SRC_REGISTER       1'b0
`define SRC_PINS           1'b1
`define POL_W              2
`define RAMP_DEFAULT       3'h0
`define FLOOR_CODE         10'h0d0
`define STEP_BASE          8'h10

`endif

/* pin_sync.v */
/*
 * Three-flop input synchroniser with a two-flop agreement filter.
 * Assumes the input is asynchronous to clock.
 */
`default_nettype none

module pin_sync (
  // Clock and reset.
  input  wire clock,
  input  wire rstn,
  // Pin and clean level.
  input  wire pin,
  output reg  level
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

/* buck_voltage_select_sequencer.v */
/*
 * Per-output voltage slot selection, ramp control and enable sequencing
 * for a four-output buck regulator, plus the interrupt pin drive.
 * Assumes the I2C register logic sits outside and hands over register
 * fields and one-cycle write strobes on the core clock; multi pins and
 * the master enable are asynchronous pins.
 */
`default_nettype none
`include "seq_defines.vh"

module buck_voltage_select_sequencer #(
  parameter BOOT_CYC = `BOOT_CYCLES,
  parameter MS_CYC   = `MS_CYCLES
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        rstn,
  // Master enable pin and multi pins.
  input  wire        master_en,
  input  wire        multi_pin_0,
  input  wire        multi_pin_1,
  input  wire        multi_pin_2,
  // Global configuration.
  input  wire [2:0]  pin_function_code,
  input  wire        discharge_en,
  // Per-output configuration, output n in bits of slice n.
  input  wire [3:0]  out_enable_bit,
  input  wire [3:0]  slot_source_bit,
  input  wire [7:0]  slot_select_field,
  input  wire [7:0]  pin_select_policy,
  input  wire [11:0] powerup_ramp_code,
  input  wire [11:0] powerdown_ramp_code,
  input  wire [11:0] transition_rise_code,
  input  wire [11:0] transition_fall_code,
  input  wire [23:0] startup_delay,
  input  wire [23:0] shutdown_delay,
  // Slot code writes: output index, slot index, data, strobes.
  input  wire [1:0]  code_out_index,
  input  wire [1:0]  code_slot_index,
  input  wire [7:0]  slot_code_upper,
  input  wire [1:0]  slot_code_lower,
  input  wire        upper_write,
  input  wire        lower_write,
  // Interrupt control.
  input  wire [3:0]  event_in,
  input  wire [3:0]  event_mask,
  input  wire [3:0]  event_clear,
  input  wire        int_active_high,
  input  wire        int_open_drain,
  // Converter controls, event status and interrupt pin drive.
  output reg  [39:0] dac_code,
  output reg  [3:0]  out_running,
  output reg  [3:0]  pull_down_on,
  output reg         bias_on,
  output reg         boot_done,
  output reg  [3:0]  event_status,
  output reg         int_out,
  output reg         int_oe
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  wire en_s;
  wire mp0;
  wire mp1;
  wire mp2;

  pin_sync u_en (.clock(clock), .rstn(rstn), .pin(master_en),   .level(en_s));
  pin_sync u_p0 (.clock(clock), .rstn(rstn), .pin(multi_pin_0), .level(mp0));
  pin_sync u_p1 (.clock(clock), .rstn(rstn), .pin(multi_pin_1), .level(mp1));
  pin_sync u_p2 (.clock(clock), .rstn(rstn), .pin(multi_pin_2), .level(mp2));

  ////////////////////////////////////////////////////////////////////
  // Slot storage and selection.

  reg [`CODE_W-1:0] slot_mem [0:15];
  reg [7:0]         upper_hold [0:15];
  integer           k;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < 16; k = k + 1) begin
        slot_mem[k]   <= {`CODE_W{1'b0}};
        upper_hold[k] <= 8'h00;
      end
    end else begin
      if (upper_write) begin
        upper_hold[{code_out_index, code_slot_index}] <= slot_code_upper;
      end
      if (lower_write) begin
        slot_mem[{code_out_index, code_slot_index}] <=
          {upper_hold[{code_out_index, code_slot_index}], slot_code_lower};
      end
    end
  end

  // Slot chosen by the global select lines under one output's policy.
  function [1:0] global_slot;
    input [1:0] policy;
    input       line1;
    input       line0;
    begin
      case (policy)
        2'h0: global_slot = 2'h0;
        2'h1: global_slot = {1'b0, line0};
        2'h2: global_slot = {line1, 1'b0};
        default: global_slot = {line1, line0};
      endcase
    end
  endfunction

  // Pin-driven slot for output n under the current pin function.
  function [1:0] pin_slot;
    input [1:0] n;
    input [2:0] mode;
    input [1:0] policy;
    input       p0;
    input       p1;
    input       p2;
    begin
      pin_slot = 2'h0;
      if (mode == `PIN_MODE_GLOBAL) begin
        pin_slot = global_slot(policy, p0, p1);
      end else if (mode == `PIN_MODE_TWO_ONE) begin
        if (n == 2'd0) pin_slot = {p1, p0};
        else if (n == 2'd1) pin_slot = {1'b0, p2};
      end else if (mode == `PIN_MODE_SINGLE) begin
        if (n == 2'd0) pin_slot = {1'b0, p0};
        else if (n == 2'd1) pin_slot = {1'b0, p1};
        else if (n == 2'd2) pin_slot = {1'b0, p2};
      end
    end
  endfunction

  // Step interval in cycles for a 3-bit ramp code; code 0 is the default rate.
  function [7:0] step_cycles;
    input [2:0] code;
    begin
      step_cycles = `STEP_BASE << code[1:0];
      if (code[2]) step_cycles = `STEP_BASE >> code[1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Boot sequence after master enable rises.

  localparam ST_OFF  = 2'd0;
  localparam ST_BOOT = 2'd1;
  localparam ST_RUN  = 2'd2;
  localparam ST_DOWN = 2'd3;

  reg [1:0]  state;
  reg [31:0] boot_cnt;
  reg [31:0] ms_cnt;
  reg [5:0]  ms_count;
  wire       all_low;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_OFF;
      boot_cnt  <= 32'h0;
      bias_on   <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          boot_done <= 1'b0;
          if (en_s) begin
            state    <= ST_BOOT;
            bias_on  <= 1'b1;
            boot_cnt <= 32'h0;
          end
        end
        ST_BOOT: begin
          boot_cnt <= boot_cnt + 32'h1;
          if (!en_s) begin
            state <= ST_DOWN;
          end else if (boot_cnt == BOOT_CYC - 1) begin
            state     <= ST_RUN;
            boot_done <= 1'b1;
          end
        end
        ST_RUN: begin
          if (!en_s) begin
            state <= ST_DOWN;
          end
        end
        default: begin
          if (all_low) begin
            state     <= ST_OFF;
            bias_on   <= 1'b0;
            boot_done <= 1'b0;
          end
        end
      endcase
    end
  end

  // Millisecond count since boot end, restarted when the master enable falls.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ms_cnt   <= 32'h0;
      ms_count <= 6'h0;
    end else begin
      if (state == ST_BOOT || state == ST_OFF || (state == ST_RUN && !en_s)) begin
        ms_count <= 6'h0;
        ms_cnt   <= 32'h0;
      end else if (ms_cnt == MS_CYC - 1) begin
        ms_cnt <= 32'h0;
        if (ms_count != 6'h3f) ms_count <= ms_count + 6'h1;
      end else begin
        ms_cnt <= ms_cnt + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-output ramp engines.

  reg [3:0]  last_state_run;
  reg [7:0]  step_cnt [0:3];
  reg [3:0]  bit_disabled;
  reg [3:0]  allow_low;
  reg [7:0]  sel_v;
  reg [39:0] target_v;
  reg [3:0]  want_v;
  reg [11:0] rcode_v;
  integer    n;
  integer    m;

  assign all_low = ~|out_running && ~|allow_low;

  // Selected slot, target code, effective enable and ramp code per output.
  always @* begin
    sel_v    = 8'h00;
    target_v = 40'h0;
    want_v   = 4'h0;
    rcode_v  = 12'h000;
    for (m = 0; m < 4; m = m + 1) begin
      sel_v[2*m+:2] = (slot_source_bit[m] == `SRC_PINS) ?
                      pin_slot(m[1:0], pin_function_code, pin_select_policy[2*m+:2],
                               mp0, mp1, mp2) :
                      slot_select_field[2*m+:2];
      target_v[10*m+:10] = slot_mem[{m[1:0], sel_v[2*m+:2]}];
      want_v[m] = en_s & out_enable_bit[m];
      // Power-up code while climbing from off, shutdown code while off, else transition codes.
      if (!out_running[m]) begin
        rcode_v[3*m+:3] = powerdown_ramp_code[3*m+:3];
      end else if (!last_state_run[m]) begin
        rcode_v[3*m+:3] = powerup_ramp_code[3*m+:3];
      end else if (target_v[10*m+:10] > dac_code[10*m+:10]) begin
        rcode_v[3*m+:3] = transition_rise_code[3*m+:3];
      end else begin
        rcode_v[3*m+:3] = transition_fall_code[3*m+:3];
      end
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dac_code       <= 40'h0;
      out_running    <= 4'h0;
      pull_down_on   <= 4'h0;
      bit_disabled   <= 4'h0;
      allow_low      <= 4'h0;
      last_state_run <= 4'h0;
      for (n = 0; n < 4; n = n + 1) step_cnt[n] <= 8'h0;
    end else begin
      for (n = 0; n < 4; n = n + 1) begin
        if (want_v[n] && state == ST_RUN && ms_count >= startup_delay[6*n+:6]) begin
          if (!out_running[n]) begin
            out_running[n]  <= 1'b1;
            bit_disabled[n] <= 1'b0;
            pull_down_on[n] <= 1'b0;
          end
          allow_low[n] <= 1'b1;
        end else if (out_running[n] && !want_v[n] &&
                     (en_s || (state == ST_DOWN && ms_count >= shutdown_delay[6*n+:6]))) begin
          out_running[n]  <= 1'b0;
          bit_disabled[n] <= en_s;
        end
        if (step_cnt[n] >= step_cycles(rcode_v[3*n+:3])) begin
          step_cnt[n] <= 8'h0;
          if (out_running[n]) begin
            if (dac_code[10*n+:10] < target_v[10*n+:10]) begin
              dac_code[10*n+:10] <= dac_code[10*n+:10] + 10'h1;
            end else if (dac_code[10*n+:10] > target_v[10*n+:10]) begin
              dac_code[10*n+:10] <= dac_code[10*n+:10] - 10'h1;
            end else begin
              last_state_run[n] <= 1'b1;
            end
          end else if (dac_code[10*n+:10] > `FLOOR_CODE) begin
            dac_code[10*n+:10] <= dac_code[10*n+:10] - 10'h1;
          end else begin
            dac_code[10*n+:10] <= 10'h0;
            allow_low[n]       <= 1'b0;
            last_state_run[n]  <= 1'b0;
            pull_down_on[n]    <= bit_disabled[n] & discharge_en;
          end
        end else begin
          step_cnt[n] <= step_cnt[n] + 8'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt latch and pin drive.

  wire pending = |(event_status & ~event_mask);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      event_status <= 4'h0;
      int_out      <= 1'b0;
      int_oe       <= 1'b0;
    end else begin
      event_status <= (event_status & ~event_clear) | event_in;
      if (int_open_drain) begin
        int_out <= 1'b0;
        int_oe  <= pending;
      end else begin
        int_out <= int_active_high ? pending : ~pending;
        int_oe  <= 1'b1;
      end
    end
  end

endmodule // buck_voltage_select_sequencer

`default_nettype wire

/* host_select_model.sv */
/* Host model: drives the selection pins and the pin mode.
   Assumes the bench hands it the wanted mode and pin levels. */
`default_nettype none
module host_select_model (
  // Clock and master enable.
  input  wire logic       clock,
  input  wire logic       master_en,
  // Wanted settings.
  input  wire logic [2:0] want_mode,
  input  wire logic [2:0] want_pins,
  // Pins toward the device.
  output var  logic [2:0] pin_function_code,
  output var  logic       multi_pin_0,
  output var  logic       multi_pin_1,
  output var  logic       multi_pin_2
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pin_function_code = 3'h4;
    {multi_pin_2, multi_pin_1, multi_pin_0} = 3'h0;
  end
  always @(posedge clock) begin
    if (!master_en) begin
      pin_function_code <= want_mode;
    end
    {multi_pin_2, multi_pin_1, multi_pin_0} <= want_pins;
  end
endmodule // host_select_model
`default_nettype wire

/* seq_checker_properties.sv */
/* Port checker for the sequencer, bound to its top module.
   Assumes one clock and an active-low asynchronous reset. */
`default_nettype none
module seq_checker (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rstn,
  // Inputs watched.
  input wire logic        discharge_en,
  input wire logic        int_open_drain,
  input wire logic [3:0]  out_enable_bit,
  input wire logic [3:0]  event_in,
  input wire logic [3:0]  event_clear,
  // Outputs watched.
  input wire logic [39:0] dac_code,
  input wire logic [3:0]  out_running,
  input wire logic [3:0]  pull_down_on,
  input wire logic        bias_on,
  input wire logic        boot_done,
  input wire logic [3:0]  event_status,
  input wire logic        int_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] d0;
  logic [3:0] keep;
  assign d0 = dac_code[9:0];
  assign keep = event_status & ~event_clear;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  a_event_set_latch: assert property (|event_in |=>
    (event_status & $past(event_in)) == $past(event_in)) else $error("event lost");
  a_event_hold_set: assert property (|keep |=>
    (event_status & $past(keep)) == $past(keep)) else $error("event dropped");
  a_event_has_cause: assert property ($changed(event_status) |->
    (event_status & ~$past(event_status) & ~$past(event_in)) == 4'h0) else $error("bad set");
  a_dac_step_one: assert property (out_running[0] && $past(out_running[0]) |->
    (d0 - $past(d0) <= 10'h1) || ($past(d0) - d0 <= 10'h1)) else $error("dac jump");
  a_boot_needs_bias: assert property (boot_done |-> bias_on) else $error("boot no bias");
  a_boot_after_bias: assert property ($rose(boot_done) |-> $past(bias_on, 8))
    else $error("boot early");
  a_push_pull_oe: assert property (!int_open_drain ##1 !int_open_drain |-> int_oe)
    else $error("oe low");
  a_run_needs_en: assert property ($rose(out_running[0]) |->
    boot_done && out_enable_bit[0]) else $error("run early");
  a_pull_needs_dis: assert property (|pull_down_on |->
    discharge_en || $past(discharge_en)) else $error("pull down");
  c_boot: cover property ($rose(boot_done));
  c_event: cover property (|event_status ##1 event_status == 4'h0);
  c_pull: cover property ($rose(pull_down_on[3]));
endmodule // seq_checker
bind buck_voltage_select_sequencer seq_checker u_checker (.*);
`default_nettype wire

/* buck_voltage_select_sequencer_tb_top.sv */
/* Self-checking bench for the sequencer with a host model.
   Assumes short boot and millisecond counts by parameter. */
`default_nettype none
module buck_voltage_select_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = 10;
  logic clock = 0, rstn = 0, master_en = 0, discharge_en = 0, upper_write = 0, lower_write = 0;
  logic int_active_high = 1, int_open_drain = 0, multi_pin_0, multi_pin_1, multi_pin_2;
  logic bias_on, boot_done, int_out, int_oe;
  logic [3:0] out_enable_bit = 4'hf, slot_source_bit = 4'h0, event_in = 4'h0;
  logic [3:0] event_mask = 4'h0, event_clear = 4'h0, out_running, pull_down_on, event_status;
  logic [7:0] slot_select_field = 8'h00, pin_select_policy = 8'h00, slot_code_upper = 8'h00;
  logic [11:0] powerup_ramp_code = 12'h000, powerdown_ramp_code = 12'h000;
  logic [11:0] transition_rise_code = 12'h000, transition_fall_code = 12'h000;
  logic [23:0] startup_delay = 24'h0c0000, shutdown_delay = 24'h080000;
  logic [1:0] code_out_index = 2'h0, code_slot_index = 2'h0, slot_code_lower = 2'h0;
  logic [2:0] want_mode = 3'h4, want_pins = 3'h0, pin_function_code;
  logic [39:0] dac_code;
  logic [9:0] codes [0:15];
  logic [15:0] lfsr = 16'h96db;
  int bad_count = 0;
  int compares = 0;
  always #12.5 clock = ~clock;
  host_select_model u_host (.*);
  buck_voltage_select_sequencer #(.BOOT_CYC(20), .MS_CYC(MS)) u_dut (.*);
  ////////////////////////////////////////
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic give_verdict;
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #2;
    end
  endtask
  function automatic logic [9:0] probe(input int s);
    case (s)
      4: return {8'h0, bias_on, boot_done};
      5: return {6'h0, out_running};
      6: return {6'h0, pull_down_on};
      7: return {6'h0, event_status};
      8: return {8'h0, int_oe, int_out};
      default: return dac_code[s*10 +: 10];
    endcase
  endfunction
  task automatic wait_for(input string what, input int s, input logic [9:0] v);
    int n;
    n = 0;
    while (probe(s) !== v && n < 20000) begin
      step(1);
      n++;
    end
    check(what, probe(s), v);
    if (n == 20000) give_verdict();
  endtask
  task automatic write_code(input int o, input int s, input logic [9:0] c, input bit both);
    code_out_index = o[1:0];
    code_slot_index = s[1:0];
    slot_code_upper = c[9:2];
    slot_code_lower = c[1:0];
    upper_write = 1;
    step(1);
    upper_write = 0;
    lower_write = both;
    step(1);
    lower_write = 0;
    if (both) codes[o*4+s] = c;
  endtask
  function automatic logic [1:0] exp_slot(input int o);
    logic [1:0] pol;
    pol = pin_select_policy[o*2 +: 2];
    if (slot_source_bit[o] !== 1'b1) return slot_select_field[o*2 +: 2];
    case (want_mode)
      3'h4: return {pol[1] & want_pins[0], pol[0] & want_pins[1]};
      3'h6: return (o == 0) ? want_pins[1:0] : {1'b0, want_pins[2]};
      default: return {1'b0, want_pins[o]};
    endcase
  endfunction
  task automatic settle(input int last);
    for (int o = 0; o <= last; o++) wait_for("dac", o, codes[o*4+exp_slot(o)]);
  endtask
  // Cycles between two ramp steps: a 16-cycle interval scaled by the code, plus reload.
  function automatic int ramp_period(input logic [2:0] c);
    return (c[2] ? (16 >> c[1:0]) : (16 << c[1:0])) + 1;
  endfunction
  // Moves output 0 by 32 codes under transition code c and times one step.
  task automatic ramp_gap(input logic [2:0] c);
    logic [9:0] seen;
    int n;
    transition_rise_code[2:0] = c;
    transition_fall_code[2:0] = c;
    write_code(0, 3, dac_code[9:0] ^ 10'h020, 1'b1);
    slot_select_field[1:0] = 2'h3;
    for (int j = 0; j < 3; j++) begin
      seen = dac_code[9:0];
      n = 0;
      while (dac_code[9:0] === seen && n < 300) begin
        step(1);
        n++;
      end
    end
    check("ramp gap", 10'(n), 10'(ramp_period(c)));
    settle(0);
    transition_rise_code[2:0] = 3'h0;
    transition_fall_code[2:0] = 3'h0;
  endtask
  task automatic power_up;
    int n;
    master_en = 1;
    wait_for("boot", 4, 10'h3);
    n = 0;
    while (out_running[3] !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    check("start delay", 10'(n >= 2*MS && n <= 4*MS), 10'h1);
    for (int i = 0; i < 16; i++) begin
      lfsr = next_rand(lfsr);
      write_code(i / 4, i % 4, 10'h0d0 + {4'h0, lfsr[5:0]}, 1'b1);
    end
  endtask
  task automatic power_down;
    master_en = 0;
    wait_for("running", 5, 10'h0);
    wait_for("bias", 4, 10'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    step(12);
    rstn = 1;
    check("reset dac", dac_code[9:0], 10'h0);
    power_up();
    settle(3);
    ramp_gap(3'h7);
    ramp_gap(3'h1);
    for (int k = 0; k < 5; k++) begin
      lfsr = next_rand(lfsr);
      slot_select_field = (k == 0) ? 8'he4 : lfsr[7:0];
      settle(3);
    end
    write_code(0, slot_select_field[1:0], 10'h3ff, 1'b0);
    step(100);
    check("upper only", dac_code[9:0], codes[slot_select_field[1:0]]);
    write_code(0, slot_select_field[1:0], 10'h0e1, 1'b1);
    settle(0);
    slot_source_bit = 4'hf;
    for (int k = 0; k < 6; k++) begin
      lfsr = next_rand(lfsr);
      pin_select_policy = (k < 4) ? {4{k[1:0]}} : lfsr[7:0];
      want_pins = lfsr[10:8];
      settle(3);
    end
    for (int m = 6; m < 8; m++) begin
      power_down();
      want_mode = m[2:0];
      step(2);
      power_up();
      for (int k = 0; k < 4; k++) begin
        lfsr = next_rand(lfsr);
        want_pins = lfsr[2:0];
        settle(m - 5);
      end
    end
    discharge_en = 1;
    out_enable_bit = 4'h7;
    wait_for("disable", 5, 10'h7);
    wait_for("pull down", 6, 10'h8);
    event_mask = 4'h2;
    event_in = 4'h3;
    step(1);
    event_in = 4'h0;
    wait_for("events", 7, 10'h3);
    wait_for("int high", 8, 10'h3);
    event_in = 4'h5;
    event_clear = 4'h5;
    step(1);
    event_in = 4'h0;
    event_clear = 4'h0;
    wait_for("set wins", 7, 10'h7);
    event_clear = 4'h5;
    step(1);
    event_clear = 4'h0;
    wait_for("cleared", 7, 10'h2);
    wait_for("masked", 8, 10'h2);
    int_active_high = 0;
    wait_for("active low", 8, 10'h3);
    int_open_drain = 1;
    wait_for("drain idle", 8, 10'h0);
    event_mask = 4'h0;
    wait_for("open drain", 8, 10'h2);
    power_down();
    give_verdict();
  end
endmodule // buck_voltage_select_sequencer_tb_top
`default_nettype wire
